// ### hw/uie_defs.svh
`ifndef UIE_DEFS_SVH
`define UIE_DEFS_SVH
// Byte addresses of the word registers
`define UIE_ADDR_CTRL_LOW 8'h00
`define UIE_ADDR_CTRL_HIGH 8'h04
`define UIE_ADDR_INT_STAT 8'h08
`define UIE_ADDR_INT_MASK 8'h0c
`define UIE_ADDR_WR_DATA 8'h10
`define UIE_ADDR_MASK 8'hfc
// Low control byte fields
`define UIE_LO_PKT_RDY 0
`define UIE_LO_FIFO_NE 1
`define UIE_LO_UNDERRUN 2
`define UIE_LO_FLUSH 3
`define UIE_LO_SEND_STALL 4
`define UIE_LO_STALL_SENT 5
`define UIE_LO_CLR_TOGGLE 6
// High control byte fields
`define UIE_HI_FORCE_TOG 3
`define UIE_HI_ISO 6
`define UIE_HI_DBL_BUF 7
// Interrupt status fields
`define UIE_IRQ_IN_EP 0
`define UIE_IRQ_UNDERRUN 1
`define UIE_IRQ_W 2
// Reset values
`define UIE_RST_BYTE 8'h00
`define UIE_RST_WORD 32'h00000000
`endif

// ### hw/uie_pkg.sv
`default_nettype none
package uie_pkg;
   // Token and handshake events from the serial engine
   typedef struct packed {
      logic in_token;
      logic ack;
      logic sof;
   } uie_link_in_t;
   // Reply chosen for one IN token
   typedef struct packed {
      logic send_data;
      logic send_zlp;
      logic send_stall;
      logic data_pid1;
   } uie_reply_t;
   typedef enum logic [1:0] {
      UIE_IDLE = 2'b00,
      UIE_WAIT_HS = 2'b01
   } uie_state_t;
endpackage
`default_nettype wire

// ### hw/uie_top.sv
`include "uie_defs.svh"
`default_nettype none
// How it works
// - ISO bit 0 selects bulk/interrupt mode, 1 selects isochronous mode.
// - Bulk and interrupt share one path; no type distinction exists.
// - Endpoint interrupt on delivery, flush of a non-empty FIFO, or STALL.
// - IN token with armed packet: send it, but no reply while a bulk packet awaits its ACK; ready clears and interrupt fires on ACK, or at once in ISO.
// - Packet ready with no data written sends a zero-length packet.
// - Send stall answers every bulk IN with STALL unless a packet awaits its ACK; ignored in ISO.
// - Each STALL sets stall sent flag and interrupts; firmware clears it.
// - Packet ready clears when a slot frees; double buffer clears at once.
// - Force toggle flips toggle every packet; otherwise on ACK, or on each ISO delivery.
// - ISO IN with no packet in the live queue sends zero-length and sets underrun.
// - With ISO update, written packets wait until after a SOF.
module uie_top #(
   parameter int SLOTS_W = 2
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic hsel_i,
   input wire logic [7:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   input wire uie_pkg::uie_link_in_t link_i,
   input wire logic iso_update_i,
   output uie_pkg::uie_reply_t reply_o,
   output logic reply_valid_o,
   output logic irq_o
);
   import uie_pkg::*;

   // Address phase capture
   logic wr_ph_reg, rd_ph_reg;
   logic [7:0] addr_ph_reg;
   wire logic take = hsel_i & hready_i & htrans_i[1];
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         wr_ph_reg <= 1'b0;
         rd_ph_reg <= 1'b0;
         addr_ph_reg <= `UIE_RST_BYTE;
      end else begin
         wr_ph_reg <= take & hwrite_i;
         rd_ph_reg <= take & ~hwrite_i;
         addr_ph_reg <= haddr_i & `UIE_ADDR_MASK;
      end
   end

   // Write decode in the data phase
   wire logic wr_lo = wr_ph_reg && addr_ph_reg == `UIE_ADDR_CTRL_LOW;
   wire logic wr_hi = wr_ph_reg && addr_ph_reg == `UIE_ADDR_CTRL_HIGH;
   wire logic wr_msk = wr_ph_reg && addr_ph_reg == `UIE_ADDR_INT_MASK;
   wire logic wr_dat = wr_ph_reg && addr_ph_reg == `UIE_ADDR_WR_DATA;
   wire logic rd_st = rd_ph_reg && addr_ph_reg == `UIE_ADDR_INT_STAT;

   // Control state
   logic pkt_rdy_reg, send_stall_reg, stall_sent_reg, underrun_reg;
   logic flush_reg, iso_reg, dbl_reg, force_tog_reg, toggle_reg;
   logic [SLOTS_W-1:0] queued_reg; // Armed packets waiting for the host
   logic [SLOTS_W-1:0] held_reg; // Armed but kept back until SOF
   logic data_seen_reg; // Bytes written since last arm
   logic [1:0] nonzero_reg; // Per-slot: packet has data
   logic [`UIE_IRQ_W-1:0] ist_reg, imsk_reg;
   uie_state_t state_reg;
   uie_reply_t reply_reg;
   logic reply_v_reg;

   // Slot capacity depends on buffering mode
   wire logic [SLOTS_W-1:0] cap = dbl_reg ? SLOTS_W'(2) : SLOTS_W'(1);
   wire logic [SLOTS_W-1:0] total = queued_reg + held_reg;
   wire logic arm = wr_lo & hwdata_i[`UIE_LO_PKT_RDY] & (total < cap);
   wire logic do_flush = wr_lo & hwdata_i[`UIE_LO_FLUSH];
   wire logic fifo_ne = total != '0;
   wire logic hold_new = iso_reg & iso_update_i;
   // Stall only applies outside isochronous mode
   wire logic stall_on = send_stall_reg & ~iso_reg;
   wire logic tok = link_i.in_token & (state_reg == UIE_IDLE);
   wire logic have_pkt = queued_reg != '0;
   wire logic t_stall = tok & stall_on;
   wire logic t_data = tok & ~stall_on & have_pkt;
   wire logic t_under = tok & ~stall_on & ~have_pkt & iso_reg;
   wire logic head_nz = nonzero_reg[0];
   // Delivery: ISO needs no handshake; bulk waits for the ACK
   wire logic deliver = (t_data & iso_reg) |
                        ((state_reg == UIE_WAIT_HS) & link_i.ack);
   // A flush of a non-empty FIFO counts as an endpoint event
   wire logic flush_ev = do_flush & fifo_ne;
   wire logic pop = deliver | flush_ev;
   wire logic ep_ev = deliver | flush_ev | t_stall;
   wire logic [`UIE_IRQ_W-1:0] ev = {t_under, ep_ev};
   // Toggle flips on ACK or ISO delivery, or on every sent packet when forced
   wire logic tog_flip = force_tog_reg ? t_data : deliver;

   // Queue counts; SOF releases held packets into the live queue
   wire logic [SLOTS_W-1:0] q_rel = link_i.sof ? held_reg : '0;
   wire logic [SLOTS_W-1:0] queued_next = queued_reg + q_rel +
      ((arm & ~hold_new) ? SLOTS_W'(1) : SLOTS_W'(0)) -
      ((pop & have_pkt) ? SLOTS_W'(1) : SLOTS_W'(0));
   wire logic [SLOTS_W-1:0] held_next = held_reg - q_rel +
      ((arm & hold_new) ? SLOTS_W'(1) : SLOTS_W'(0));
   wire logic [SLOTS_W-1:0] tot_next = queued_next + held_next;

   // Endpoint state
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         pkt_rdy_reg <= 1'b0;
         queued_reg <= '0;
         held_reg <= '0;
         state_reg <= UIE_IDLE;
      end else begin
         queued_reg <= queued_next;
         held_reg <= held_next;
         // Ready reads 1 only while no slot is free
         pkt_rdy_reg <= tot_next >= cap;
         if (t_data & ~iso_reg)
            state_reg <= UIE_WAIT_HS;
         else if (link_i.ack | link_i.in_token)
            state_reg <= UIE_IDLE;
      end
   end

   // Zero-length tracking per slot, FIFO order
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         data_seen_reg <= 1'b0;
         nonzero_reg <= 2'b00;
      end else begin
         data_seen_reg <= arm ? 1'b0 : (data_seen_reg | wr_dat);
         if (do_flush & ~fifo_ne)
            nonzero_reg <= 2'b00;
         else if (arm)
            nonzero_reg[total[0]] <= data_seen_reg | wr_dat;
         else if (pop)
            nonzero_reg <= {1'b0, nonzero_reg[1]};
      end
   end

   // Software bits and flags; hardware set beats software clear
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         send_stall_reg <= 1'b0;
         stall_sent_reg <= 1'b0;
         underrun_reg <= 1'b0;
         flush_reg <= 1'b0;
         iso_reg <= 1'b0;
         dbl_reg <= 1'b0;
         force_tog_reg <= 1'b0;
      end else begin
         if (wr_lo)
            send_stall_reg <= hwdata_i[`UIE_LO_SEND_STALL];
         stall_sent_reg <= t_stall |
            (wr_lo ? hwdata_i[`UIE_LO_STALL_SENT] & stall_sent_reg
                   : stall_sent_reg);
         underrun_reg <= t_under |
            (wr_lo ? hwdata_i[`UIE_LO_UNDERRUN] & underrun_reg
                   : underrun_reg);
         flush_reg <= 1'b0; // completes within one cycle
         if (wr_hi) begin
            iso_reg <= hwdata_i[`UIE_HI_ISO];
            dbl_reg <= hwdata_i[`UIE_HI_DBL_BUF];
            force_tog_reg <= hwdata_i[`UIE_HI_FORCE_TOG];
         end
      end
   end

   // Data toggle; clear wins since firmware resets the pipe
   always_ff @(posedge clk_i) begin
      if (reset_i)
         toggle_reg <= 1'b0;
      else if (wr_lo & hwdata_i[`UIE_LO_CLR_TOGGLE])
         toggle_reg <= 1'b0;
      else if (tog_flip)
         toggle_reg <= ~toggle_reg;
   end

   // Reply to each stall, data or underrun token, one cycle pulse; same path for bulk and interrupt
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         reply_reg <= '0;
         reply_v_reg <= 1'b0;
      end else begin
         reply_v_reg <= t_stall | t_data | t_under;
         reply_reg.send_stall <= t_stall;
         reply_reg.send_data <= t_data & head_nz;
         reply_reg.send_zlp <= (t_data & ~head_nz) | t_under;
         reply_reg.data_pid1 <= toggle_reg;
      end
   end

   // Interrupts: sticky status cleared by read, event wins over clear
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         ist_reg <= '0;
         imsk_reg <= '0;
         irq_o <= 1'b0;
      end else begin
         ist_reg <= ev | (rd_st ? '0 : ist_reg);
         if (wr_msk)
            imsk_reg <= hwdata_i[`UIE_IRQ_W-1:0];
         irq_o <= |((ev | (rd_st ? '0 : ist_reg)) & imsk_reg);
      end
   end

   // Read mux; clear toggle bit always reads 0
   wire logic [7:0] lo_rd = {2'b00, stall_sent_reg, send_stall_reg,
      flush_reg, underrun_reg, fifo_ne, pkt_rdy_reg};
   wire logic [7:0] hi_rd = {dbl_reg, iso_reg, 2'b00, force_tog_reg, 3'b000};
   wire logic [7:0] rd_a = haddr_i & `UIE_ADDR_MASK;
   wire logic [31:0] rd_mux =
      (rd_a == `UIE_ADDR_CTRL_LOW) ? {24'h000000, lo_rd} :
      (rd_a == `UIE_ADDR_CTRL_HIGH) ? {24'h000000, hi_rd} :
      (rd_a == `UIE_ADDR_INT_STAT) ? {30'h00000000, ist_reg} :
      (rd_a == `UIE_ADDR_INT_MASK) ? {30'h00000000, imsk_reg} :
      `UIE_RST_WORD;

   // Read data registered at the address phase; zero wait states
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         hrdata_o <= `UIE_RST_WORD;
         hreadyout_o <= 1'b1;
         hresp_o <= 1'b0;
      end else begin
         hrdata_o <= (take & ~hwrite_i) ? rd_mux : `UIE_RST_WORD;
         hreadyout_o <= 1'b1;
         hresp_o <= 1'b0;
      end
   end

   assign reply_o = reply_reg;
   assign reply_valid_o = reply_v_reg;

   // Checks
   sequence s_stall_tok;
      link_i.in_token && state_reg == UIE_IDLE && send_stall_reg && !iso_reg;
   endsequence
   property p_stall_reply;
      @(posedge clk_i) disable iff (reset_i)
      s_stall_tok |=> reply_valid_o && reply_o.send_stall && stall_sent_reg;
   endproperty
   a_stall_reply: assert property (p_stall_reply)
      else $error("Stall token not answered with STALL");
   property p_iso_no_stall;
      @(posedge clk_i) disable iff (reset_i)
      iso_reg |=> !reply_o.send_stall;
   endproperty
   a_iso_no_stall: assert property (p_iso_no_stall)
      else $error("STALL sent in isochronous mode");
   property p_underrun;
      @(posedge clk_i) disable iff (reset_i)
      (link_i.in_token && state_reg == UIE_IDLE && iso_reg &&
       queued_reg == '0) |=> reply_o.send_zlp && underrun_reg &&
      ist_reg[`UIE_IRQ_UNDERRUN];
   endproperty
   a_underrun: assert property (p_underrun)
      else $error("ISO underrun not flagged");
   property p_clr_tog;
      @(posedge clk_i) disable iff (reset_i)
      (wr_lo && hwdata_i[`UIE_LO_CLR_TOGGLE]) |=> !toggle_reg;
   endproperty
   a_clr_tog: assert property (p_clr_tog)
      else $error("Toggle not cleared");
   property p_ack_flip;
      @(posedge clk_i) disable iff (reset_i)
      (state_reg == UIE_WAIT_HS && link_i.ack && !force_tog_reg && !wr_lo)
      |=> toggle_reg != $past(toggle_reg);
   endproperty
   a_ack_flip: assert property (p_ack_flip)
      else $error("Toggle did not flip on ACK");
   property p_stall_sticky;
      @(posedge clk_i) disable iff (reset_i)
      (stall_sent_reg && !wr_lo) |=> stall_sent_reg;
   endproperty
   a_stall_sticky: assert property (p_stall_sticky)
      else $error("Stall sent flag cleared by hardware");
   property p_irq;
      @(posedge clk_i) disable iff (reset_i)
      // Checked at the next edge, so a quick status read cannot hide it
      (ep_ev && imsk_reg[`UIE_IRQ_IN_EP] && !wr_msk) |=>
      irq_o && ist_reg[`UIE_IRQ_IN_EP];
   endproperty
   a_irq: assert property (p_irq)
      else $error("Endpoint event did not interrupt");
   property p_rdy_free;
      @(posedge clk_i) disable iff (reset_i)
      (total < cap) |-> !pkt_rdy_reg || $changed(dbl_reg);
   endproperty
   a_rdy_free: assert property (p_rdy_free)
      else $error("Packet ready set while a slot is free");

   // Data tokens: the packet or an empty one goes out, never a STALL
   sequence s_data_tok;
      link_i.in_token && state_reg == UIE_IDLE && queued_reg != '0 &&
      !(send_stall_reg && !iso_reg);
   endsequence
   property p_data_reply;
      @(posedge clk_i) disable iff (reset_i)
      s_data_tok |=> reply_valid_o && !reply_o.send_stall &&
         (reply_o.send_data || reply_o.send_zlp);
   endproperty
   a_data_reply: assert property (p_data_reply)
      else $error("Armed packet not sent on IN token");
   property p_zlp_reply;
      @(posedge clk_i) disable iff (reset_i)
      s_data_tok ##0 !head_nz |=> reply_o.send_zlp && !reply_o.send_data;
   endproperty
   a_zlp_reply: assert property (p_zlp_reply)
      else $error("Empty packet not sent as zero length");
   property p_iso_deliver;
      @(posedge clk_i) disable iff (reset_i)
      s_data_tok ##0 iso_reg |=> ist_reg[`UIE_IRQ_IN_EP];
   endproperty
   a_iso_deliver: assert property (p_iso_deliver)
      else $error("ISO delivery did not raise the interrupt");
   property p_force_flip;
      @(posedge clk_i) disable iff (reset_i)
      s_data_tok ##0 (force_tog_reg &&
         !(wr_lo && hwdata_i[`UIE_LO_CLR_TOGGLE])) |=>
      toggle_reg != $past(toggle_reg);
   endproperty
   a_force_flip: assert property (p_force_flip)
      else $error("Forced toggle did not flip on a sent packet");

   // Flush and frame start
   property p_flush_irq;
      @(posedge clk_i) disable iff (reset_i)
      (wr_lo && hwdata_i[`UIE_LO_FLUSH] && fifo_ne) |=>
      ist_reg[`UIE_IRQ_IN_EP];
   endproperty
   a_flush_irq: assert property (p_flush_irq)
      else $error("Flush of a loaded FIFO did not interrupt");
   property p_iso_hold;
      @(posedge clk_i) disable iff (reset_i)
      (arm && hold_new && !link_i.sof) |=> held_reg != '0;
   endproperty
   a_iso_hold: assert property (p_iso_hold)
      else $error("Packet under ISO update not held for frame start");
   property p_sof_release;
      @(posedge clk_i) disable iff (reset_i)
      (link_i.sof && held_reg != '0) |=> queued_reg != '0;
   endproperty
   a_sof_release: assert property (p_sof_release)
      else $error("Held packet not released by frame start");
endmodule
`default_nettype wire

// ### verification/testbench.sv
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import uie_pkg::*;
   logic clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic hsel = 1'b0, hwrite = 1'b0, iso_upd = 1'b0;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'b00;
   logic [31:0] hwdata = 32'h0, hrdata;
   logic hreadyout, hresp, rvalid, irq, v;
   uie_link_in_t link;
   uie_reply_t reply, r;
   int n_errors = 0, num_checks = 0;
   // The slave's hreadyout is the bus's hready
   uie_top DUT (.clk_i(clk_i), .reset_i(reset_i), .hsel_i(hsel),
      .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
      .hsize_i(3'b010), .hwdata_i(hwdata), .hready_i(hreadyout),
      .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp),
      .link_i(link), .iso_update_i(iso_upd), .reply_o(reply),
      .reply_valid_o(rvalid), .irq_o(irq));
   uie_host_model host (.clk_i(clk_i), .reply_i(reply),
      .reply_valid_i(rvalid), .link_o(link));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Single word transfer; a read is compared with e
   task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic [31:0] e);
      @(posedge clk_i);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= w;
      // Address phase stands until hready is seen high at an edge
      do begin
         @(posedge clk_i);
      end while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      // Data phase; read data and response are taken at the ready edge
      do begin
         @(posedge clk_i);
      end while (hreadyout !== 1'b1);
      chk(hresp, 1'b0);
      if (!w) chk(hrdata, e);
   endtask
   // Reply kind as {valid, data, zlp, stall}
   task automatic tok(input int ack, input logic [3:0] e);
      host.in_xfer(ack, r, v);
      chk({v, r.send_data, r.send_zlp, r.send_stall}, e);
   endtask
   // The interrupt follows its cause by one cycle; allow two
   task automatic ck_irq(input logic e);
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
      chk(irq, e);
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      forever #20 clk_i = ~clk_i;
   end
   // The whole run needs under 300 cycles
   initial begin
      repeat (5000) @(posedge clk_i);
      n_errors++;
      end_sim();
   end
   initial begin
      repeat (16) @(posedge clk_i);
      reset_i <= 1'b0;
      // Reset values; an unmapped word ignores writes
      bus(0, 8'h00, 0, 32'h0);
      bus(0, 8'h04, 0, 32'h0);
      bus(0, 8'h0c, 0, 32'h0);
      bus(1, 8'h20, 32'hff, 0);
      bus(0, 8'h20, 0, 32'h0);
      $display("test reset done");
      // Bulk packet delivered, interrupt masked then unmasked
      bus(1, 8'h10, 32'h5a, 0);
      bus(1, 8'h00, 32'h1, 0);
      bus(0, 8'h00, 0, 32'h3);
      tok(4, 4'hc);
      chk(r.data_pid1, 1'b0);
      bus(0, 8'h00, 0, 32'h0);
      ck_irq(1'b0);
      bus(1, 8'h0c, 32'h3, 0);
      ck_irq(1'b1);
      bus(0, 8'h08, 0, 32'h1);
      bus(0, 8'h08, 0, 32'h0);
      ck_irq(1'b0);
      $display("test bulk done");
      // Lost handshake keeps the toggle; zero-length packet
      bus(1, 8'h10, 32'h1, 0);
      bus(1, 8'h00, 32'h1, 0);
      tok(0, 4'hc);
      chk(r.data_pid1, 1'b1);
      tok(0, 4'h0);
      tok(1, 4'hc);
      chk(r.data_pid1, 1'b1);
      bus(1, 8'h00, 32'h1, 0);
      tok(1, 4'ha);
      chk(r.data_pid1, 1'b0);
      // Toggle cleared, then flipped without any handshake
      bus(1, 8'h00, 32'h40, 0);
      bus(0, 8'h00, 0, 32'h0);
      bus(1, 8'h04, 32'h08, 0);
      bus(1, 8'h00, 32'h1, 0);
      tok(0, 4'ha);
      chk(r.data_pid1, 1'b0);
      tok(0, 4'h0);
      tok(1, 4'ha);
      chk(r.data_pid1, 1'b1);
      bus(1, 8'h04, 32'h0, 0);
      bus(0, 8'h08, 0, 32'h1);
      $display("test toggle done");
      // Halted pipe
      bus(1, 8'h00, 32'h10, 0);
      tok(0, 4'h9);
      tok(0, 4'h9);
      bus(0, 8'h00, 0, 32'h30);
      bus(0, 8'h08, 0, 32'h1);
      bus(1, 8'h00, 32'h0, 0);
      bus(0, 8'h00, 0, 32'h0);
      tok(0, 4'h0);
      $display("test stall done");
      // Two slots filled, then flushed one packet at a time
      bus(1, 8'h04, 32'h80, 0);
      bus(1, 8'h10, 32'h7, 0);
      bus(1, 8'h00, 32'h1, 0);
      bus(0, 8'h00, 0, 32'h2);
      bus(0, 8'h08, 0, 32'h0);
      bus(1, 8'h10, 32'h8, 0);
      bus(1, 8'h00, 32'h1, 0);
      bus(0, 8'h00, 0, 32'h3);
      bus(1, 8'h00, 32'h08, 0);
      bus(0, 8'h00, 0, 32'h2);
      bus(0, 8'h08, 0, 32'h1);
      bus(1, 8'h00, 32'h08, 0);
      bus(0, 8'h00, 0, 32'h0);
      bus(0, 8'h08, 0, 32'h1);
      $display("test flush done");
      // Isochronous: underrun, stall ignored, held until frame start
      bus(1, 8'h04, 32'h40, 0);
      tok(0, 4'ha);
      bus(0, 8'h00, 0, 32'h4);
      bus(0, 8'h08, 0, 32'h2);
      bus(1, 8'h00, 32'h10, 0);
      tok(0, 4'ha);
      bus(0, 8'h00, 0, 32'h14);
      bus(1, 8'h00, 32'h0, 0);
      @(posedge clk_i);
      iso_upd <= 1'b1;
      bus(1, 8'h10, 32'h9, 0);
      bus(1, 8'h00, 32'h1, 0);
      tok(0, 4'ha);
      host.sof();
      tok(0, 4'hc);
      $display("test iso done");
      end_sim();
   end
endmodule
`default_nettype wire

// ### verification/uie_host_model.sv
`default_nettype none
// Host side of the link: IN tokens, ACKs and frame starts
module uie_host_model (
   input wire logic clk_i,
   input wire uie_pkg::uie_reply_t reply_i,
   input wire logic reply_valid_i,
   output uie_pkg::uie_link_in_t link_o
);
   timeunit 1ns;
   timeprecision 1ns;
   import uie_pkg::*;
   initial link_o = '0;
   // One frame start; an ISO host sends one token per frame
   task automatic sof();
      @(posedge clk_i);
      link_o.sof <= 1'b1;
      @(posedge clk_i);
      link_o.sof <= 1'b0;
   endtask
   // Token, bounded wait for a reply, ACK after ack cycles (0: none)
   task automatic in_xfer(input int ack, output uie_reply_t r,
      output logic v);
      @(posedge clk_i);
      link_o.in_token <= 1'b1;
      @(posedge clk_i);
      link_o.in_token <= 1'b0;
      v = 1'b0;
      // The reply is taken at the edge that closes its cycle
      for (int n = 0; n < 4 && v !== 1'b1; n++) begin
         @(posedge clk_i);
         v = reply_valid_i;
         r = reply_i;
      end
      if (v !== 1'b1) r = '0;
      // Only data gets a handshake; a STALL or silence gets none
      if (ack > 0 && (r.send_data || r.send_zlp)) begin
         repeat (ack) @(posedge clk_i);
         link_o.ack <= 1'b1;
         @(posedge clk_i);
         link_o.ack <= 1'b0;
      end
   endtask
endmodule
`default_nettype wire
